//--- mmsel_asserts.sv
// Port assertions for the measurement mode select block.
`timescale 1ns/100ps
`include "mmsel_defs.vh"
module mmsel_asserts (
	input wire logic                     ref_clk_in,
	input wire logic                     rst_in,
	input wire logic [`MMSEL_ADDR_W-1:0] reg_addr_in,
	input wire logic                     reg_wr_in,
	input wire logic                     reg_rd_in,
	input wire logic [7:0]               reg_wdata_in,
	input wire logic [7:0]               reg_rdata_out,
	input wire logic                     reg_rvalid_out,
	input wire logic [2:0]               zero_cross_in,
	input wire logic                     sample_vld_in,
	input wire logic [2:0]               zero_cross_phase_enable_out,
	input wire logic [2:0]               zero_cross_gated_out,
	input wire logic [2:0]               voltage_dip_detect_en_out,
	input wire logic [2:0]               zx_timeout_en_out,
	input wire logic [1:0]               period_source_select_out,
	input wire logic [1:0]               peak_source_select_out,
	input wire logic                     line_period_vld_out,
	input wire logic                     voltage_peak_flag_out,
	input wire logic                     current_peak_flag_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// A write that hits the mode register.
	wire mode_wr = reg_wr_in && (reg_addr_in == `MMSEL_MODE_ADDR);
	wire [2:0] zen = zero_cross_phase_enable_out;
	// Written field values, named so that $past sees plain signals.
	wire [1:0] wr_period = reg_wdata_in[1:0];
	wire [1:0] wr_peak   = reg_wdata_in[3:2];
	wire [2:0] wr_zx     = reg_wdata_in[6:4];
	a_read_valid: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read strobe gave no valid");
	a_rdata_idle: assert property (!(reg_rd_in &&
		reg_addr_in == `MMSEL_MODE_ADDR) |=> reg_rdata_out == 8'h00)
		else $error("read data not zero");
	a_rsvd_bit: assert property (reg_rvalid_out |-> !reg_rdata_out[7])
		else $error("reserved bit read back set");
	a_period_copy: assert property (mode_wr |-> ##2
		period_source_select_out == $past(wr_period, 2))
		else $error("period select not applied");
	a_peak_copy: assert property (mode_wr |-> ##2
		peak_source_select_out == $past(wr_peak, 2))
		else $error("peak select not applied");
	a_zx_copy: assert property (mode_wr |-> ##2
		zen == $past(wr_zx, 2))
		else $error("phase enables not applied");
	a_gated_mask: assert property ($stable(zen) |->
		zero_cross_gated_out == ($past(zero_cross_in) & zen))
		else $error("crossing passed a disabled phase");
	a_dip_timeout: assert property (voltage_dip_detect_en_out == zen
		&& zx_timeout_en_out == zen)
		else $error("dip or timeout enable differs");
	a_vpeak_cause: assert property (!sample_vld_in |=>
		!voltage_peak_flag_out) else $error("voltage flag without sample");
	a_ipeak_cause: assert property (!sample_vld_in |=>
		!current_peak_flag_out) else $error("current flag without sample");
	c_mode_write: cover property (mode_wr);
	c_read: cover property (reg_rvalid_out);
	c_vpeak: cover property (voltage_peak_flag_out);
	c_period: cover property (line_period_vld_out);
endmodule
bind mmsel_top mmsel_asserts mmsel_asserts_inst (.ref_clk_in, .rst_in,
	.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
	.reg_rvalid_out, .zero_cross_in, .sample_vld_in,
	.zero_cross_phase_enable_out, .zero_cross_gated_out,
	.voltage_dip_detect_en_out, .zx_timeout_en_out,
	.period_source_select_out, .peak_source_select_out,
	.line_period_vld_out, .voltage_peak_flag_out, .current_peak_flag_out);

//--- mmsel_defs.vh
// Constants for the measurement mode select block.
`ifndef MMSEL_DEFS_VH
`define MMSEL_DEFS_VH

// ------------------------------------------------------------------
// Register map
// ------------------------------------------------------------------
`define MMSEL_ADDR_W         6
`define MMSEL_MODE_ADDR      6'h0b
`define MMSEL_MODE_RESET     8'h70

// ------------------------------------------------------------------
// Field positions of the measurement mode register
// ------------------------------------------------------------------
`define MMSEL_PERIOD_LSB     0
`define MMSEL_PERIOD_MSB     1
`define MMSEL_PEAK_LSB       2
`define MMSEL_PEAK_MSB       3
`define MMSEL_ZX_LSB         4
`define MMSEL_ZX_MSB         6
`define MMSEL_WRITE_MASK     8'h7f

// ------------------------------------------------------------------
// Phase source encodings
// ------------------------------------------------------------------
`define MMSEL_SRC_A          2'h0
`define MMSEL_SRC_B          2'h1
`define MMSEL_SRC_C          2'h2
`define MMSEL_SRC_RSVD       2'h3

// ------------------------------------------------------------------
// Datapath widths and timing counts
// ------------------------------------------------------------------
`define MMSEL_SAMPLE_W       16
`define MMSEL_PERIOD_W       16
`define MMSEL_PERIOD_MAX     16'hffff

`endif

//--- mmsel_host.sv
// Host model that drives the register port of the block.
`timescale 1ns/100ps
`include "mmsel_defs.vh"
module mmsel_host (
	input  wire                     ref_clk_in, // Block clock.
	input  wire [7:0]               rdata_in,   // Read data.
	input  wire                     rvalid_in,  // Read data valid.
	output reg  [`MMSEL_ADDR_W-1:0] addr_out,   // Register address.
	output reg                      wr_out,     // Write strobe.
	output reg                      rd_out,     // Read strobe.
	output reg  [7:0]               wdata_out   // Write data.
);
	// The port idles with both strobes low.
	initial begin
		addr_out = 6'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// One-cycle write strobe; data is scrambled once it is released.
	task wr_reg(input [`MMSEL_ADDR_W-1:0] a, input [7:0] d);
		begin
			@(posedge ref_clk_in);
			addr_out <= a;
			wdata_out <= d;
			wr_out <= 1'b1;
			@(posedge ref_clk_in);
			wr_out <= 1'b0;
			wdata_out <= ~d;
		end
	endtask
	// One-cycle read strobe; the answer stands in the next cycle.
	task rd_reg(input [`MMSEL_ADDR_W-1:0] a, output [7:0] d, output v);
		begin
			@(posedge ref_clk_in);
			addr_out <= a;
			rd_out <= 1'b1;
			@(posedge ref_clk_in);
			rd_out <= 1'b0;
			#1;
			d = rdata_in;
			v = rvalid_in;
		end
	endtask
endmodule

//--- mmsel_peak.v
// Peak comparator: magnitude of a signed sample against a threshold.
`timescale 1ns/100ps
`include "mmsel_defs.vh"

module mmsel_peak (
	input  wire                         ref_clk_in,   // Block clock.
	input  wire                         rst_in,       // Async reset, high.
	input  wire                         enable_in,    // Valid source chosen.
	input  wire                         sample_vld_in, // New sample strobe.
	input  wire [`MMSEL_SAMPLE_W-1:0]   sample_in,    // Signed sample.
	input  wire [`MMSEL_SAMPLE_W-1:0]   threshold_in, // Unsigned level.
	output reg                          over_out      // One-cycle pulse.
);

	// Magnitude of the two's complement sample.
	wire [`MMSEL_SAMPLE_W-1:0] mag_w;

	// The most negative code maps to 8000h, its true unsigned magnitude.
	assign mag_w = sample_in[`MMSEL_SAMPLE_W-1] ?
		(~sample_in + {{(`MMSEL_SAMPLE_W-1){1'b0}}, 1'b1}) : sample_in;

	// ------------------------------------------------------------------
	// Compare stage
	// ------------------------------------------------------------------

	// A sample strictly above the level raises a single pulse.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			over_out <= 1'b0;
		end else begin
			over_out <= enable_in & sample_vld_in & (mag_w > threshold_in);
		end
	end

endmodule

//--- mmsel_top.v
// Measurement mode register and the phase selection it drives.
// Function
// RULE1 - Bits 1:0 pick period phase, reset 0.
// RULE2 - Bits 3:2 pick peak detection phase.
// RULE3 - Selected voltage above threshold sets flag.
// RULE4 - Selected current above threshold sets flag.
// RULE5 - Bits 6:4 choose phases counting zero crossings.
// RULE6 - Cleared phase skips timeout, crossing, period, dip.
// RULE7 - Bit4 A, bit5 B, bit6 C; reset 7.
// RULE8 - Host writes register 0Bh; device applies fields.
// RULE9 - Bit 7 reads zero, writes ignored.
`timescale 1ns/100ps
`include "mmsel_defs.vh"

module mmsel_top (
	input  wire                          ref_clk_in,      // 40 MHz clock.
	input  wire                          rst_in,          // Async reset.
	// Register port from the serial interface decoder.
	input  wire [`MMSEL_ADDR_W-1:0]      reg_addr_in,     // Register address.
	input  wire                          reg_wr_in,       // Write strobe.
	input  wire                          reg_rd_in,       // Read strobe.
	input  wire [7:0]                    reg_wdata_in,    // Write data.
	output reg  [7:0]                    reg_rdata_out,   // Read data.
	output reg                           reg_rvalid_out,  // Read data valid.
	// Per-phase zero crossing pulses, bit 0 is phase A.
	input  wire [2:0]                    zero_cross_in,   // Raw crossings.
	// Per-phase samples for peak detection.
	input  wire                          sample_vld_in,   // Sample strobe.
	input  wire [`MMSEL_SAMPLE_W-1:0]    volt_a_in,       // Phase A voltage.
	input  wire [`MMSEL_SAMPLE_W-1:0]    volt_b_in,       // Phase B voltage.
	input  wire [`MMSEL_SAMPLE_W-1:0]    volt_c_in,       // Phase C voltage.
	input  wire [`MMSEL_SAMPLE_W-1:0]    curr_a_in,       // Phase A current.
	input  wire [`MMSEL_SAMPLE_W-1:0]    curr_b_in,       // Phase B current.
	input  wire [`MMSEL_SAMPLE_W-1:0]    curr_c_in,       // Phase C current.
	input  wire [`MMSEL_SAMPLE_W-1:0]    voltage_peak_threshold_in, // Level.
	input  wire [`MMSEL_SAMPLE_W-1:0]    current_peak_threshold_in, // Level.
	// Results towards the measurement functions.
	output reg  [2:0]                    zero_cross_phase_enable_out, // Field.
	output reg  [2:0]                    zero_cross_gated_out, // Counted.
	output reg  [2:0]                    voltage_dip_detect_en_out, // Dip.
	output reg  [2:0]                    zx_timeout_en_out, // Timeout.
	output reg  [1:0]                    period_source_select_out, // Field.
	output reg  [1:0]                    peak_source_select_out, // Field.
	output reg  [`MMSEL_PERIOD_W-1:0]    line_period_out, // Period cycles.
	output reg                           line_period_vld_out, // New period.
	output wire                          voltage_peak_flag_out, // Set pulse.
	output wire                          current_peak_flag_out  // Set pulse.
);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------

	// Turns a two-bit source code into a one-hot phase; reserved is none.
	function [2:0] src_onehot;
		input [1:0] code;
		begin
			case (code)
				`MMSEL_SRC_A: begin
					src_onehot = 3'h1;
				end
				`MMSEL_SRC_B: begin
					src_onehot = 3'h2;
				end
				`MMSEL_SRC_C: begin
					src_onehot = 3'h4;
				end
				default: begin
					src_onehot = 3'h0;
				end
			endcase
		end
	endfunction

	// Picks one of three samples by a one-hot phase; none gives zero.
	function [`MMSEL_SAMPLE_W-1:0] pick;
		input [2:0]                  sel;
		input [`MMSEL_SAMPLE_W-1:0]  a;
		input [`MMSEL_SAMPLE_W-1:0]  b;
		input [`MMSEL_SAMPLE_W-1:0]  c;
		begin
			pick = ({`MMSEL_SAMPLE_W{sel[0]}} & a) |
			       ({`MMSEL_SAMPLE_W{sel[1]}} & b) |
			       ({`MMSEL_SAMPLE_W{sel[2]}} & c);
		end
	endfunction

	// ------------------------------------------------------------------
	// Measurement mode register
	// ------------------------------------------------------------------

	reg  [7:0] mode_r;      // Stored register, bit 7 always zero.
	wire       mode_hit_w;  // Access addresses this register.

	assign mode_hit_w = (reg_addr_in == `MMSEL_MODE_ADDR); // RULE8

	// A write replaces the three fields at once; bit 7 is masked off.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_r <= `MMSEL_MODE_RESET; // RULE1 RULE7
		end else if (reg_wr_in && mode_hit_w) begin
			mode_r <= reg_wdata_in & `MMSEL_WRITE_MASK; // RULE8 RULE9
		end
	end

	// Reads return the stored value one cycle after the strobe.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in && mode_hit_w) begin
				reg_rdata_out <= mode_r & `MMSEL_WRITE_MASK; // RULE9
			end else begin
				// Unmapped addresses read as zero.
				reg_rdata_out <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------------

	wire [1:0] period_sel_w;  // Period source code.
	wire [1:0] peak_sel_w;    // Peak source code.
	wire [2:0] phase_en_w;    // Per-phase enables, bit 0 is phase A.
	wire [2:0] period_oh_w;   // Period phase, one-hot.
	wire [2:0] peak_oh_w;     // Peak phase, one-hot.

	assign period_sel_w = mode_r[`MMSEL_PERIOD_MSB:`MMSEL_PERIOD_LSB]; // RULE1
	assign peak_sel_w   = mode_r[`MMSEL_PEAK_MSB:`MMSEL_PEAK_LSB];     // RULE2
	assign phase_en_w   = mode_r[`MMSEL_ZX_MSB:`MMSEL_ZX_LSB];         // RULE7
	assign period_oh_w  = src_onehot(period_sel_w);                    // RULE1
	assign peak_oh_w    = src_onehot(peak_sel_w);                      // RULE2

	// ------------------------------------------------------------------
	// Per-phase gating
	// ------------------------------------------------------------------

	wire [2:0] zx_gated_nxt;  // Crossings of enabled phases, next value.

	// Each phase is gated by its own enable bit, one copy per phase.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gate_phase
			// Only enabled phases pass their crossing on.
			assign zx_gated_nxt[g] =
				zero_cross_in[g] & phase_en_w[g]; // RULE5 RULE6
		end
	endgenerate

	// One process owns each output vector, so no bit has two drivers.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			zero_cross_gated_out      <= 3'h0;
			voltage_dip_detect_en_out <= 3'h7;
			zx_timeout_en_out         <= 3'h7;
		end else begin
			zero_cross_gated_out      <= zx_gated_nxt; // RULE5 RULE6
			voltage_dip_detect_en_out <= phase_en_w;   // RULE6
			zx_timeout_en_out         <= phase_en_w;   // RULE6
		end
	end

	// Field copies for the neighbouring measurement functions.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			zero_cross_phase_enable_out <= 3'h7;
			period_source_select_out    <= `MMSEL_SRC_A;
			peak_source_select_out      <= `MMSEL_SRC_A;
		end else begin
			zero_cross_phase_enable_out <= phase_en_w; // RULE5
			period_source_select_out    <= period_sel_w; // RULE1
			peak_source_select_out      <= peak_sel_w;   // RULE2
		end
	end

	// ------------------------------------------------------------------
	// Line period measurement
	// ------------------------------------------------------------------

	reg  [`MMSEL_PERIOD_W-1:0] per_cnt_r;   // Cycles since last crossing.
	reg                        per_armed_r; // A first crossing was seen.
	wire                       per_zx_w;    // Crossing of the chosen phase.

	// The chosen phase must also be enabled to be measured.
	assign per_zx_w = |(zero_cross_in & period_oh_w & phase_en_w); // RULE1 RULE6

	// The counter saturates so a stopped line never wraps to a short
	// false period; the first crossing only arms the measurement.
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			per_cnt_r           <= {`MMSEL_PERIOD_W{1'b0}};
			per_armed_r         <= 1'b0;
			line_period_out     <= {`MMSEL_PERIOD_W{1'b0}};
			line_period_vld_out <= 1'b0;
		end else if (per_zx_w) begin
			per_cnt_r           <= {`MMSEL_PERIOD_W{1'b0}};
			per_armed_r         <= 1'b1;
			line_period_vld_out <= per_armed_r;
			if (per_armed_r) begin
				line_period_out <= per_cnt_r;
			end
		end else begin
			line_period_vld_out <= 1'b0;
			if (per_cnt_r != `MMSEL_PERIOD_MAX) begin
				per_cnt_r <= per_cnt_r + {{(`MMSEL_PERIOD_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ------------------------------------------------------------------
	// Peak detection
	// ------------------------------------------------------------------

	wire [`MMSEL_SAMPLE_W-1:0] pk_volt_w; // Voltage of the peak phase.
	wire [`MMSEL_SAMPLE_W-1:0] pk_curr_w; // Current of the peak phase.
	wire                       pk_en_w;   // A valid phase is chosen.

	assign pk_volt_w = pick(peak_oh_w, volt_a_in, volt_b_in, volt_c_in);
	assign pk_curr_w = pick(peak_oh_w, curr_a_in, curr_b_in, curr_c_in);
	assign pk_en_w   = |peak_oh_w; // RULE2

	// Voltage level check; the pulse sets the flag in interrupt status.
	mmsel_peak u_volt_peak (
		.ref_clk_in    (ref_clk_in),
		.rst_in        (rst_in),
		.enable_in     (pk_en_w),
		.sample_vld_in (sample_vld_in),
		.sample_in     (pk_volt_w),
		.threshold_in  (voltage_peak_threshold_in),
		.over_out      (voltage_peak_flag_out) // RULE3
	);

	// Current level check; the pulse sets the flag in interrupt status.
	mmsel_peak u_curr_peak (
		.ref_clk_in    (ref_clk_in),
		.rst_in        (rst_in),
		.enable_in     (pk_en_w),
		.sample_vld_in (sample_vld_in),
		.sample_in     (pk_curr_w),
		.threshold_in  (current_peak_threshold_in),
		.over_out      (current_peak_flag_out) // RULE4
	);

endmodule

//--- tb_top.sv
// Self-checking bench for the measurement mode select block.
`timescale 1ns/100ps
module tb_top;
	reg         ref_clk_in; // Block clock.
	reg         rst_in;     // Async reset.
	reg  [2:0]  zx;         // Crossing pulses.
	reg         vld;        // Sample strobe.
	reg  [15:0] va, vb, vc; // Phase samples, shared by both channels.
	reg  [15:0] vthr, ithr; // Voltage and current peak levels.
	wire [5:0]  addr;
	wire        wr, rd, rvalid, vpk, ipk, pvld;
	wire [7:0]  wdata, rdata;
	wire [2:0]  zen, zg, den, ten;
	wire [1:0]  psel, ksel;
	wire [15:0] per;
	integer     fail_count, comparisons, cycles, s;
	reg  [7:0]  d;
	reg         v;
	mmsel_host mmsel_host_inst (.ref_clk_in(ref_clk_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata));
	// Voltage level 4 and current level 5 tell the two channels apart.
	mmsel_top mmsel_top_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.zero_cross_in(zx), .sample_vld_in(vld), .volt_a_in(va),
		.volt_b_in(vb), .volt_c_in(vc), .curr_a_in(va), .curr_b_in(vb),
		.curr_c_in(vc), .voltage_peak_threshold_in(vthr),
		.current_peak_threshold_in(ithr),
		.zero_cross_phase_enable_out(zen), .zero_cross_gated_out(zg),
		.voltage_dip_detect_en_out(den), .zx_timeout_en_out(ten),
		.period_source_select_out(psel), .peak_source_select_out(ksel),
		.line_period_out(per), .line_period_vld_out(pvld),
		.voltage_peak_flag_out(vpk), .current_peak_flag_out(ipk));
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	// Compares one value and counts the outcome.
	task check(input [8*10:1] name, input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("Error %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task results;
		begin
			$display("Comparisons %0d mismatches %0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// One-cycle crossing pulse on the given phases.
	task pulse(input [2:0] b);
		begin
			@(posedge ref_clk_in);
			zx <= b;
			@(posedge ref_clk_in);
			zx <= 3'h0;
			#1;
		end
	endtask
	// One sample; unselected phases carry a level far above both limits.
	task sample(input [1:0] k, input [15:0] x, input ev, input ei);
		begin
			@(posedge ref_clk_in);
			va <= (k == 2'h0) ? x : 16'h7000;
			vb <= (k == 2'h1) ? x : 16'h7000;
			vc <= (k == 2'h2) ? x : 16'h7000;
			vld <= 1'b1;
			@(posedge ref_clk_in);
			vld <= 1'b0;
			#1;
			check("vpeak", vpk, ev);
			check("ipeak", ipk, ei);
		end
	endtask
	// Cuts a hung run short.
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	initial begin
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		rst_in = 1'b1;
		zx = 3'h0;
		vld = 1'b0;
		va = 16'h0000;
		vb = 16'h0000;
		vc = 16'h0000;
		vthr = 16'h0004;
		ithr = 16'h0005;
		repeat (12) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		#1;
		check("zen_rst", zen, 16'h7);
		check("psel_rst", psel, 16'h0);
		mmsel_host_inst.rd_reg(6'h0b, d, v);
		check("mode_rst", d, 16'h70);
		// Phase B period; a phase A crossing in between must not count.
		mmsel_host_inst.wr_reg(6'h0b, 8'h71);
		pulse(3'h2);
		pulse(3'h1);
		check("pvld_a", pvld, 16'h0);
		@(posedge ref_clk_in);
		pulse(3'h2);
		check("pvld_b", pvld, 16'h1);
		check("period", per, 16'h4);
		// Phase B disabled, then the reserved source: no measurement.
		for (s = 0; s < 2; s = s + 1) begin
			mmsel_host_inst.wr_reg(6'h0b, s ? 8'h73 : 8'h51);
			pulse(3'h7);
			pulse(3'h7);
			check("pvld_off", pvld, 16'h0);
			check("zgated", zg, s ? 16'h7 : 16'h5);
			check("dip_en", den, s ? 16'h7 : 16'h5);
			check("tmo_en", ten, s ? 16'h7 : 16'h5);
		end
		// Bit 7 is dropped and an unmapped write leaves the register.
		mmsel_host_inst.wr_reg(6'h0b, 8'hff);
		mmsel_host_inst.wr_reg(6'h0c, 8'h00);
		mmsel_host_inst.rd_reg(6'h0b, d, v);
		check("mode_rd", d, 16'h7f);
		check("psel", psel, 16'h3);
		check("ksel", ksel, 16'h3);
		check("zen", zen, 16'h7);
		mmsel_host_inst.rd_reg(6'h0c, d, v);
		check("unmapped", d, 16'h0);
		check("rvalid", v, 16'h1);
		// Every peak source, each at and around both limits.
		for (s = 0; s < 4; s = s + 1) begin
			mmsel_host_inst.wr_reg(6'h0b, {4'h7, s[1:0], 2'h0});
			sample(s[1:0], 16'hfffb, s < 3, 1'b0);
			sample(s[1:0], 16'hfffa, s < 3, s < 3);
			sample(s[1:0], 16'h0004, 1'b0, 1'b0);
		end
		// Raised levels on phase B move where each channel trips.
		mmsel_host_inst.wr_reg(6'h0b, 8'h74);
		vthr <= 16'h0100;
		ithr <= 16'h0200;
		sample(2'h1, 16'h0150, 1'b1, 1'b0);
		sample(2'h1, 16'h0250, 1'b1, 1'b1);
		results;
	end
endmodule
